// file: logic/smb_map.vh
`ifndef SMB_MAP_VH
`define SMB_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SMB_OFS_CONTROL      4'h0
`define SMB_OFS_TIMING       4'h4
`define SMB_OFS_STATUS       4'h8

// ----------------------------------------
// Reset values, control write mask and fixed bits
// ----------------------------------------
`define SMB_RST_CONTROL      32'h000030db
`define SMB_RST_TIMING       32'h0fffffff
`define SMB_CONTROL_WMASK    32'h000fff7f
`define SMB_CONTROL_FIXED    32'h00000080

// ----------------------------------------
// bank_control fields
// ----------------------------------------
`define SMB_CTL_BANK_EN      0
`define SMB_CTL_MUX          1
`define SMB_CTL_TYPE_LO      2
`define SMB_CTL_TYPE_HI      3
`define SMB_CTL_WIDTH_LO     4
`define SMB_CTL_WIDTH_HI     5
`define SMB_CTL_BURST_EN     8
`define SMB_CTL_WAIT_POL     9
`define SMB_CTL_WAIT_CFG     11
`define SMB_CTL_WRITE_ALLOW  12
`define SMB_CTL_WAIT_EN      13
`define SMB_CTL_CLK_WRITE    19

// ----------------------------------------
// bank_timing fields
// ----------------------------------------
`define SMB_TIM_TURN_LO      16
`define SMB_TIM_TURN_HI      19
`define SMB_TIM_DIV_LO       20
`define SMB_TIM_DIV_HI       23
`define SMB_TIM_LAT_LO       24
`define SMB_TIM_LAT_HI       27
`define SMB_TIM_AMODE_LO     28
`define SMB_TIM_AMODE_HI     29

// ----------------------------------------
// Field codes
// ----------------------------------------
`define SMB_TYPE_PSRAM       2'h1
`define SMB_TYPE_NOR         2'h2
`define SMB_WIDTH_16         2'h1
`define SMB_AMODE_NONE       2'h0

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define SMB_ADDR_CYCLES      4'h1
`define SMB_LAT_EXTRA        5'h2

`endif

// file: logic/smb_clk_div.v
`timescale 1ns/1ps

// ----------------------------------------
// Memory clock divider: period is div+1 system cycles, two for a div of zero
// ----------------------------------------
module smb_clk_div (
    input  wire       clk_sys,
    input  wire       reset,
    input  wire [3:0] div,
    output reg        mclk_reg,
    output reg        rise_reg,
    output reg        fall_reg
);
    reg  [3:0] cnt_reg;
    wire [3:0] top;
    wire [3:0] half;
    wire [3:0] cnt_next;
    wire [3:0] cnt_after;

    // Zero would mean a clock as fast as the system clock; clamp to two cycles
    assign top      = (div == 4'h0) ? 4'h1 : div;
    // Halved before adding so a divider of fifteen cannot wrap to zero
    assign half      = {1'b0, top[3:1]} + {3'h0, top[0]};
    assign cnt_next  = (cnt_reg >= top) ? 4'h0 : cnt_reg + 4'h1;
    assign cnt_after = (cnt_next >= top) ? 4'h0 : cnt_next + 4'h1;

    always @(posedge clk_sys) begin
        if (reset) begin
            cnt_reg  <= 4'h0;
            mclk_reg <= 1'b0;
            rise_reg <= 1'b0;
            fall_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            mclk_reg <= (cnt_next < half);
            rise_reg <= (cnt_next == 4'h0);
            // Leads the fall by one cycle so strobes move with the falling edge
            fall_reg <= (cnt_after == half);
        end
    end
endmodule

// file: logic/smb_ctrl.v
`timescale 1ns/1ps
`include "smb_map.vh"

// Overview of operation
// - A 16-bit request becomes one external burst of length one.
// - A 32-bit request becomes one external burst of two half-words.
// - Burst reads work with PSRAM or NOR flash memory types.
// - Divider setting one gives a memory clock of two system cycles.
// - Burst writes are allowed only with the PSRAM memory type.
// - First data beat comes after latency plus two memory clocks.
// - Turnaround field sets chip select idle time between accesses.
// - With wait detection on, wait is sampled after latency and stalls beats.
// - Wait polarity bit picks high or low active wait level.
// - During wait the clock runs, chip select and outputs hold.
module smb_ctrl (
    input  wire        clk_sys,
    input  wire        reset,
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    input  wire        req_valid,
    input  wire        req_write,
    input  wire        req_size32,
    input  wire [25:0] req_addr,
    input  wire [31:0] req_wdata,
    output reg         req_done,
    output reg         req_error,
    output reg  [31:0] req_rdata,
    output reg         req_busy,
    output wire        memory_clock,
    output reg         chip_select_n,
    output reg         address_valid_n,
    output reg         output_enable_n,
    output reg         write_enable_n,
    output reg  [9:0]  mem_addr_hi,
    output reg  [15:0] mem_ad_out,
    output reg         mem_ad_oe,
    input  wire [15:0] mem_ad_in,
    input  wire        wait_n
);
    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_LAT  = 3'h2;
    localparam ST_DATA = 3'h3;
    localparam ST_TURN = 3'h4;

    reg  [31:0] bank_control_reg;
    reg  [31:0] bank_timing_reg;
    reg  [2:0]  state_reg;
    reg  [3:0]  cnt_reg;
    reg         pend_reg;
    reg         wr_reg;
    reg         two_reg;
    reg         beat_reg;
    reg  [25:0] addr_reg;
    reg  [31:0] wdata_reg;
    reg  [15:0] low_reg;
    reg  [15:0] cap_reg;
    reg         wait_prev_reg;
    reg  [31:0] rd_next;
    wire [15:0] cap_now;
    wire        rise_en;
    wire        fall_en;
    wire        wait_active;
    wire        beat_ok;
    wire        ok_mode;
    wire        sel_ctl;
    wire        sel_tim;
    wire [31:0] be_mask;

    smb_clk_div u_div (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .div      (bank_timing_reg[`SMB_TIM_DIV_HI:`SMB_TIM_DIV_LO]),
        .mclk_reg (memory_clock),
        .rise_reg (rise_en),
        .fall_reg (fall_en)
    );

    // ----------------------------------------
    // Memory pins
    // ----------------------------------------
    // Memory answers on the derived clock, so no synchroniser; a deeper
    // pipe would miss beats at the fastest divider settings
    assign cap_now = rise_en ? mem_ad_in : cap_reg;

    assign wait_active = (wait_n == bank_control_reg[`SMB_CTL_WAIT_POL]);
    // Config bit chooses whether wait spoils this beat or the next one
    assign beat_ok = !(bank_control_reg[`SMB_CTL_WAIT_EN] &&
                      (bank_control_reg[`SMB_CTL_WAIT_CFG] ? wait_active : wait_prev_reg));

    // Async fields play no part; only burst mode is served here
    // Reads take either memory type; only writes test it
    assign ok_mode = bank_control_reg[`SMB_CTL_BANK_EN] &&
                     bank_control_reg[`SMB_CTL_BURST_EN] &&
                     (bank_control_reg[`SMB_CTL_WIDTH_HI:`SMB_CTL_WIDTH_LO] == `SMB_WIDTH_16) &&
                     (!wr_reg || (bank_control_reg[`SMB_CTL_WRITE_ALLOW] &&
                                  bank_control_reg[`SMB_CTL_CLK_WRITE] &&
                                  (bank_control_reg[`SMB_CTL_TYPE_HI:`SMB_CTL_TYPE_LO] ==
                                   `SMB_TYPE_PSRAM)));

    // ----------------------------------------
    // Memory access sequencer
    // ----------------------------------------
    always @(posedge clk_sys) begin
        if (reset) begin
            state_reg       <= ST_IDLE;
            cnt_reg         <= 4'h0;
            pend_reg        <= 1'b0;
            wr_reg          <= 1'b0;
            two_reg         <= 1'b0;
            beat_reg        <= 1'b0;
            addr_reg        <= 26'h0;
            wdata_reg       <= 32'h0;
            low_reg         <= 16'h0;
            cap_reg         <= 16'h0;
            wait_prev_reg   <= 1'b0;
            req_done        <= 1'b0;
            req_error       <= 1'b0;
            req_rdata       <= 32'h0;
            req_busy        <= 1'b0;
            chip_select_n   <= 1'b1;
            address_valid_n <= 1'b1;
            output_enable_n <= 1'b1;
            write_enable_n  <= 1'b1;
            mem_addr_hi     <= 10'h0;
            mem_ad_out      <= 16'h0;
            mem_ad_oe       <= 1'b0;
        end else begin
            req_done  <= 1'b0;
            req_error <= 1'b0;
            if (rise_en) begin
                cap_reg <= mem_ad_in;
            end
            if (req_valid && !pend_reg && !req_busy) begin
                pend_reg  <= 1'b1;
                req_busy  <= 1'b1;
                wr_reg    <= req_write;
                two_reg   <= req_size32;
                addr_reg  <= req_addr;
                wdata_reg <= req_wdata;
            end
            if (fall_en) begin
                case (state_reg)
                    ST_IDLE: begin
                        if (pend_reg && ok_mode) begin
                            state_reg       <= ST_ADDR;
                            beat_reg        <= 1'b0;
                            chip_select_n   <= 1'b0;
                            address_valid_n <= 1'b0;
                            write_enable_n  <= !wr_reg;
                            mem_addr_hi     <= addr_reg[25:16];
                            mem_ad_out      <= addr_reg[15:0];
                            mem_ad_oe       <= 1'b1;
                        end else if (pend_reg) begin
                            pend_reg  <= 1'b0;
                            req_busy  <= 1'b0;
                            req_error <= 1'b1;
                        end
                    end
                    ST_ADDR: begin
                        state_reg       <= ST_LAT;
                        address_valid_n <= 1'b1;
                        cnt_reg         <= bank_timing_reg[`SMB_TIM_LAT_HI:`SMB_TIM_LAT_LO];
                        mem_ad_oe       <= wr_reg;
                        mem_ad_out      <= wdata_reg[15:0];
                    end
                    ST_LAT: begin
                        // One address clock plus latency+1 here makes latency+2
                        if (cnt_reg == 4'h0) begin
                            state_reg       <= ST_DATA;
                            output_enable_n <= wr_reg;
                            wait_prev_reg   <= 1'b0;
                        end else begin
                            cnt_reg <= cnt_reg - 4'h1;
                        end
                    end
                    ST_DATA: begin
                        wait_prev_reg <= bank_control_reg[`SMB_CTL_WAIT_EN] && wait_active;
                        // A stalled beat lets the clock run and keeps select and bus unchanged
                        if (beat_ok) begin
                            if (!wr_reg && !beat_reg) begin
                                low_reg <= cap_now;
                            end
                            if (two_reg && !beat_reg) begin
                                beat_reg   <= 1'b1;
                                mem_ad_out <= wdata_reg[31:16];
                            end else begin
                                state_reg       <= ST_TURN;
                                cnt_reg         <= bank_timing_reg[`SMB_TIM_TURN_HI:`SMB_TIM_TURN_LO];
                                chip_select_n   <= 1'b1;
                                output_enable_n <= 1'b1;
                                write_enable_n  <= 1'b1;
                                mem_ad_oe       <= 1'b0;
                                pend_reg        <= 1'b0;
                                req_done        <= 1'b1;
                                req_busy        <= 1'b0;
                                if (two_reg) begin
                                    req_rdata <= {cap_now, low_reg};
                                end else begin
                                    req_rdata <= {16'h0, cap_now};
                                end
                            end
                        end
                    end
                    ST_TURN: begin
                        if (cnt_reg == 4'h0) begin
                            state_reg <= ST_IDLE;
                        end else begin
                            cnt_reg <= cnt_reg - 4'h1;
                        end
                    end
                    default: begin
                        state_reg <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // Register slave
    // ----------------------------------------
    assign sel_ctl = (avs_address == `SMB_OFS_CONTROL);
    assign sel_tim = (avs_address == `SMB_OFS_TIMING);
    assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    always @* begin
        case (avs_address)
            `SMB_OFS_CONTROL: rd_next = bank_control_reg;
            `SMB_OFS_TIMING:  rd_next = bank_timing_reg;
            `SMB_OFS_STATUS:  rd_next = {27'h0, pend_reg, req_busy, state_reg};
            default:          rd_next = 32'h0;
        endcase
    end

    // Every access answers on the second edge; extra wait keeps it simple
    always @(posedge clk_sys) begin
        if (reset) begin
            avs_waitrequest  <= 1'b1;
            avs_readdata     <= 32'h0;
            bank_control_reg <= `SMB_RST_CONTROL;
            bank_timing_reg  <= `SMB_RST_TIMING;
        end else begin
            avs_waitrequest <= 1'b1;
            if ((avs_read || avs_write) && avs_waitrequest) begin
                avs_waitrequest <= 1'b0;
                avs_readdata    <= avs_read ? rd_next : 32'h0;
                if (avs_write && sel_ctl) begin
                    bank_control_reg <= ((bank_control_reg & ~(be_mask & `SMB_CONTROL_WMASK)) |
                                         (avs_writedata & be_mask & `SMB_CONTROL_WMASK)) |
                                        `SMB_CONTROL_FIXED;
                end
                if (avs_write && sel_tim) begin
                    bank_timing_reg <= (bank_timing_reg & ~be_mask) | (avs_writedata & be_mask);
                end
            end
        end
    end
endmodule

// file: verification/smb_ctrl_checker.sv
`timescale 1ns/1ps
module smb_ctrl_checker (
    input wire        clk_sys,
    input wire        reset,
    input wire [3:0]  avs_address,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_writedata,
    input wire        avs_waitrequest,
    input wire        req_valid,
    input wire        req_busy,
    input wire        req_done,
    input wire        req_error,
    input wire        memory_clock,
    input wire        chip_select_n,
    input wire        address_valid_n,
    input wire        output_enable_n,
    input wire        write_enable_n,
    input wire        mem_ad_oe
);
    // ----------------------------------------
    // Shadow timing and idle fall count
    // ----------------------------------------
    reg [31:0] tim_reg;
    reg        mclk_reg;
    reg [7:0]  gap_reg;
    always @(posedge clk_sys) begin
        mclk_reg <= memory_clock;
        if (reset)
            tim_reg <= 32'h0fffffff;
        else if (avs_write && !avs_waitrequest && avs_address == 4'h4)
            tim_reg <= avs_writedata;
        // Starts saturated: first access after reset has no predecessor
        if (reset)
            gap_reg <= 8'hff;
        else if (!chip_select_n)
            gap_reg <= 8'h00;
        else if (mclk_reg && !memory_clock && gap_reg != 8'hff)
            gap_reg <= gap_reg + 8'h01;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("register access not answered next cycle");
    a_done_ends: assert property (req_done |-> !req_busy && !req_error ##1 !req_done)
        else $error("done not a lone pulse");
    a_take_busy: assert property (req_valid && !req_busy |-> ##[1:2] (req_busy || req_error))
        else $error("request not taken");
    a_error_pulse: assert property (req_error |-> !req_done ##1 !req_error)
        else $error("error not a lone pulse");
    a_adv_frame: assert property ($fell(address_valid_n) |-> !chip_select_n && mem_ad_oe && output_enable_n)
        else $error("address phase without select");
    a_clk_div_one: assert property (!chip_select_n && tim_reg[23:20] == 4'h1 |=> $changed(memory_clock))
        else $error("memory clock not two system cycles");
    a_turn_gap: assert property ($fell(chip_select_n) |-> gap_reg >= {4'h0, tim_reg[19:16]})
        else $error("turnaround too short");
    a_oe_read: assert property (!output_enable_n |-> !chip_select_n && write_enable_n && !mem_ad_oe)
        else $error("read phase bus conflict");
    a_cs_release: assert property ($rose(chip_select_n) |-> output_enable_n && write_enable_n && !mem_ad_oe)
        else $error("strobes left active after select");
    a_edge_align: assert property ($changed({chip_select_n, output_enable_n, write_enable_n}) |-> !memory_clock)
        else $error("strobe moved off falling memory edge");
endmodule
bind smb_ctrl smb_ctrl_checker smb_ctrl_checker_inst (.clk_sys, .reset, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_waitrequest, .req_valid, .req_busy, .req_done, .req_error, .memory_clock,
    .chip_select_n, .address_valid_n, .output_enable_n, .write_enable_n, .mem_ad_oe);

// file: verification/smb_mem_model.sv
`timescale 1ns/1ps
module smb_mem_model (
    input wire          clk_sys,
    input wire          memory_clock,
    input wire          chip_select_n,
    input wire          address_valid_n,
    input wire          output_enable_n,
    input wire          write_enable_n,
    input wire [9:0]    mem_addr_hi,
    input wire [15:0]   mem_ad_out,
    input wire          wait_pol,
    input wire [3:0]    stall,
    input wire [3:0]    lat,
    output logic [15:0] ad_far,
    output wire         wait_n,
    output int          beats
);
    logic [15:0] mem [int];
    logic [25:0] base = 26'h0;
    logic        mclk_q = 1'b0;
    logic        in_wait = 1'b0;
    logic        wait_on = 1'b0;
    int          left = 0;
    int          skip = 0;
    initial ad_far = 16'h0;
    initial beats = 0;
    assign wait_n = wait_on ? wait_pol : !wait_pol;
    function automatic logic [15:0] word(int k);
        return mem.exists(k) ? mem[k] : k[15:0] ^ 16'h5a5a;
    endfunction
    // Edges seen one system cycle late, after the controller's own update
    always @(posedge clk_sys) begin
        mclk_q <= memory_clock;
        if (!mclk_q && memory_clock && !chip_select_n) begin
            if (!address_valid_n) begin
                base = {mem_addr_hi, mem_ad_out};
                beats = 0;
                left = stall;
                in_wait = 1'b0;
                skip = lat + 1;
            end else if (skip > 0) begin
                skip--;
            end else if ((!output_enable_n || !write_enable_n) && !in_wait) begin
                if (!write_enable_n)
                    mem[base[25:1] + beats] = mem_ad_out;
                beats++;
            end
        end
        if (mclk_q && !memory_clock) begin
            in_wait = wait_on;
            wait_on = !chip_select_n && (!output_enable_n || !write_enable_n) && skip == 0 && left > 0;
            if (wait_on)
                left--;
        end
        // Released bus toggles so stale data cannot pass
        if (!chip_select_n && !output_enable_n)
            ad_far <= word(base[25:1] + beats);
        else
            ad_far <= ~ad_far;
    end
endmodule

// file: verification/tb_sync_mux_burst_mem_ctrl.sv
`timescale 1ns/1ps
`include "smb_map.vh"
module tb_sync_mux_burst_mem_ctrl;
    logic        clk_sys, reset, avs_read, avs_write, req_valid, req_write, req_size32, wait_pol;
    logic [3:0]  avs_address, stall;
    logic [31:0] avs_writedata, req_wdata, rd, seed, tim;
    logic [25:0] req_addr;
    wire  [31:0] avs_readdata, req_rdata;
    wire         avs_waitrequest, req_done, req_error, req_busy, memory_clock, chip_select_n;
    wire         address_valid_n, output_enable_n, write_enable_n, mem_ad_oe, wait_n;
    wire  [9:0]  mem_addr_hi;
    wire  [15:0] mem_ad_out, mem_ad_in, ad_far;
    int          beats, err_total, check_count;
    logic [15:0] mdl [int];
    logic [31:0] ctl_tab [6] = '{32'h000831d7, 32'h000831db, 32'h000031d7, 32'h000821d7,
                                 32'h000831c7, 32'h000830d7};
    smb_ctrl smb_ctrl_inst (.clk_sys, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .req_valid, .req_write, .req_size32,
        .req_addr, .req_wdata, .req_done, .req_error, .req_rdata, .req_busy, .memory_clock, .chip_select_n,
        .address_valid_n, .output_enable_n, .write_enable_n, .mem_addr_hi, .mem_ad_out, .mem_ad_oe,
        .mem_ad_in, .wait_n);
    smb_mem_model smb_mem_model_inst (.clk_sys, .memory_clock, .chip_select_n, .address_valid_n,
        .output_enable_n, .write_enable_n, .mem_addr_hi, .mem_ad_out, .wait_pol, .stall, .lat(tim[27:24]), .ad_far,
        .wait_n, .beats);
    assign mem_ad_in = mem_ad_oe ? mem_ad_out : ad_far;
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [15:0] word(int k);
        return mdl.exists(k) ? mdl[k] : k[15:0] ^ 16'h5a5a;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0)
            @(posedge clk_sys);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic cfg(input logic [31:0] c, input logic [31:0] t);
        wait_pol = c[9];
        tim = t;
        bus(1'b1, `SMB_OFS_CONTROL, c, rd);
        bus(1'b1, `SMB_OFS_TIMING, t, rd);
    endtask
    task automatic req(input logic w, input logic s, input logic [25:0] a, input logic [31:0] d, input logic bad);
        int k;
        k = a >> 1;
        req_valid <= 1'b1;
        req_write <= w;
        req_size32 <= s;
        req_addr <= a;
        req_wdata <= d;
        @(posedge clk_sys);
        req_valid <= 1'b0;
        while (req_done !== 1'b1 && req_error !== 1'b1)
            @(posedge clk_sys);
        check({31'h0, req_error}, {31'h0, bad});
        if (!bad) begin
            check(32'(beats), s ? 32'h2 : 32'h1);
            if (w) begin
                mdl[k] = d[15:0];
                if (s)
                    mdl[k + 1] = d[31:16];
            end else
                check(req_rdata & (s ? 32'hffffffff : 32'h0000ffff), {s ? word(k + 1) : 16'h0, word(k)});
        end
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // Whole run needs well under a tenth of this span
    initial begin
        #200000;
        err_total++;
        test_done();
    end
    initial begin
        reset = 1'b1; avs_read = 1'b0; avs_write = 1'b0; avs_address = 4'h0; avs_writedata = 32'h0;
        req_valid = 1'b0; req_write = 1'b0; req_size32 = 1'b0; req_addr = 26'h0; req_wdata = 32'h0;
        wait_pol = 1'b0; stall = 4'h0; seed = 32'h1359; err_total = 0; check_count = 0; tim = 32'h0;
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        bus(1'b0, `SMB_OFS_CONTROL, 32'h0, rd);
        check(rd, `SMB_RST_CONTROL);
        bus(1'b0, `SMB_OFS_TIMING, 32'h0, rd);
        check(rd, `SMB_RST_TIMING);
        bus(1'b1, 4'hc, 32'hffffffff, rd);
        bus(1'b0, 4'hc, 32'h0, rd);
        check(rd, 32'h0);
        req(1'b0, 1'b1, 26'h100, 32'h0, 1'b1);
        bus(1'b1, `SMB_OFS_CONTROL, 32'hffffffff, rd);
        bus(1'b0, `SMB_OFS_CONTROL, 32'h0, rd);
        check(rd, `SMB_CONTROL_WMASK | `SMB_CONTROL_FIXED);
        $display("test registers done");
        for (int i = 0; i < 6; i++) begin
            cfg(ctl_tab[i], 32'h01320000);
            req(1'b1, 1'b1, 26'h40 + 26'(i * 8), 32'hc3a5_0f00 + i, i >= 1);
            req(1'b0, 1'b1, 26'h40 + 26'(i * 8), 32'h0, i >= 4);
        end
        $display("test config table done");
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            tim = {6'h0, seed[29:28], 4'h3, 2'h0, seed[31:30], 16'h0};
            cfg(32'h000831d7, tim);
            req(1'b1, seed[0], {seed[25:2], 2'b00}, lfsr(seed), 1'b0);
            req(1'b0, seed[0], {seed[25:2], 2'b00}, 32'h0, 1'b0);
        end
        $display("test random bursts done");
        stall = 4'h3;
        for (int p = 0; p < 2; p++) begin
            cfg(32'h000831d7 | (p << 9), 32'h01320000);
            req(1'b1, 1'b1, 26'h2000, 32'h1234_5678 + p, 1'b0);
            req(1'b0, 1'b1, 26'h2000, 32'h0, 1'b0);
        end
        stall = 4'h0;
        $display("test wait done");
        for (int dv = 1; dv < 3; dv++) begin
            cfg(32'h000831d7, {8'h01, 4'(dv), 4'h1, 16'h0});
            req(1'b1, 1'b0, 26'h3002, 32'h0000_beef + dv, 1'b0);
            req(1'b0, 1'b0, 26'h3002, 32'h0, 1'b0);
        end
        $display("test divider done");
        test_done();
    end
endmodule
